//--- logic/perf_monitor_counter_bank.sv
/*
 * Bank of event counters with per-monitor enable, overflow flag and interrupt
 * enable, reached over an APB slave.
 * Assumes event inputs and prohibit come from logic in the pclk domain.
 */
// Added by the designer: the APB slave port and the register offsets.
// Summary of operation
// - Each monitor has a readable value, an enable bit, event select and filter.
// - Counting monitors also have an overflow flag and an interrupt enable bit.
// - A bank with counters drives one overflow interrupt request output.
// - Each value width is chosen, never above sixty-four bits.
// - The widest value width reads from a size field of the config register.
// - Values up to 32 bits sit word aligned, wider ones doubleword aligned.
// - At most 256 monitors for narrow values, 128 for wide ones.
// - Monitor count is chosen and reads from a count field of config.
// - Flags and enables are reached only through paired set and clear registers.
// - Bit q of set or clear register m maps to monitor q plus 32m.
// - Writing one to a set bit forces the mapped bit to one.
// - Writing one to a clear bit forces the mapped bit to zero.
// - Writing zero to a set or clear bit leaves the mapped bit alone.
// - Reading a set or clear bit returns the mapped bit's present state.
// - No software increment register is provided, as the feature is deprecated.
// - All event counters share one width.
// - The unit runs while run enable is one, stops while zero.
// - A counter counts only when running, enabled, unprohibited and its event occurs.
// - An overflowing increment wraps through zero and sets the overflow flag.
// - Interrupt asserts while any flag and its enable are set and the unit runs.
`timescale 1ns/1ps
`include "perf_mon_defs.svh"

module perf_monitor_counter_bank
   import perf_mon_pkg::*;
(
   // Clock and reset
   input  wire logic                                      pclk,
   input  wire logic                                      presetn,
   // APB slave
   input  wire logic                                      psel,
   input  wire logic                                      penable,
   input  wire logic                                      pwrite,
   input  wire logic [11:0]                               paddr,
   input  wire logic [31:0]                               pwdata,
   input  wire logic [3:0]                                pstrb,
   output logic      [31:0]                               prdata,
   output logic                                           pready,
   output logic                                           pslverr,
   // Monitored component
   input  wire logic [`PM_NUM_MON*(1<<`PM_EVT_WIDTH)-1:0] event_in,
   input  wire logic                                      count_prohibit,
   // Overflow interrupt request
   output logic                                           overflow_irq
);

   localparam int NM = `PM_NUM_MON;
   localparam int CW = `PM_CNT_WIDTH;
   localparam int EW = `PM_EVT_WIDTH;
   localparam int NE = 1 << EW;

   // =======================================================================
   // Sanity of the chosen shape
   // =======================================================================
   // Counter width and monitor count are fixed inside the documented limits;
   // with at most 32 monitors one set/clear register of each kind suffices.
   localparam int MAX_MON = (CW <= 32) ? `PM_MAX_MON_NARROW : `PM_MAX_MON_WIDE;
   localparam bit SHAPE_OK = (CW <= `PM_MAX_WIDTH) && (NM <= MAX_MON) && (NM <= 32);
   localparam int VSTRIDE = (CW <= 32) ? 4 : 8;

   // =======================================================================
   // State
   // =======================================================================
   logic [CW-1:0] value_q  [NM];
   logic [CW-1:0] value_d  [NM];
   logic [EW-1:0] evsel_q  [NM];
   logic [EW-1:0] evsel_d  [NM];
   logic [NE-1:0] filt_q   [NM];
   logic [NE-1:0] filt_d   [NM];
   logic [NM-1:0] cnten_q;
   logic [NM-1:0] cnten_d;
   logic [NM-1:0] inten_q;
   logic [NM-1:0] inten_d;
   logic [NM-1:0] ovs_q;
   logic [NM-1:0] ovs_d;
   logic          run_q;
   logic          run_d;
   logic [31:0]   prdata_d;
   logic          pready_q;
   logic          pready_d;
   logic          pslverr_d;
   logic          irq_d;

   // =======================================================================
   // Address decode
   // =======================================================================
   reg_sel_e      sel;
   int unsigned   idx;
   logic          wr_en;
   logic          rd_en;
   logic [31:0]   wmask;
   logic [NM-1:0] wbits;

   // Transfer acts in its first access cycle and completes in the second; pready drops the next.
   assign wr_en = psel && penable && !pready_q && pwrite;
   assign rd_en = psel && penable && !pready_q && !pwrite;

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{pstrb[b]}};
      end
   end
   assign wbits = pwdata[NM-1:0] & wmask[NM-1:0];

   always_comb begin
      sel = SEL_NONE;
      idx = 0;
      if (paddr >= `PM_OFF_VALUE_BASE && paddr < `PM_OFF_VALUE_BASE + 12'(NM * VSTRIDE)
          && paddr[1:0] == 2'b00) begin
         sel = SEL_VALUE;
         idx = 32'(paddr - `PM_OFF_VALUE_BASE) / VSTRIDE;
         if ((32'(paddr) % VSTRIDE) != 0) begin
            sel = SEL_NONE;
         end
      end else if (paddr >= `PM_OFF_EVSEL_BASE && paddr < `PM_OFF_EVSEL_BASE + 12'(NM * 4)
                   && paddr[1:0] == 2'b00) begin
         sel = SEL_EVSEL;
         idx = 32'((paddr - `PM_OFF_EVSEL_BASE) >> 2);
      end else if (paddr >= `PM_OFF_FILT_BASE && paddr < `PM_OFF_FILT_BASE + 12'(NM * 4)
                   && paddr[1:0] == 2'b00) begin
         sel = SEL_FILT;
         idx = 32'((paddr - `PM_OFF_FILT_BASE) >> 2);
      end else begin
         unique case (paddr)
            `PM_OFF_CNTEN_SET, `PM_OFF_CNTEN_CLR: sel = SEL_CNTEN;
            `PM_OFF_INTEN_SET, `PM_OFF_INTEN_CLR: sel = SEL_INTEN;
            `PM_OFF_OVS_SET, `PM_OFF_OVS_CLR:     sel = SEL_OVS;
            `PM_OFF_CONTROL:                      sel = SEL_CTRL;
            `PM_OFF_CONFIG:                       sel = SEL_CONFIG;
            default:                              sel = SEL_NONE;
         endcase
      end
   end

   // Set registers sit at the lower offset of each pair, except the overflow pair, whose clear register is lower.
   logic is_set;
   assign is_set = (paddr == `PM_OFF_CNTEN_SET) || (paddr == `PM_OFF_INTEN_SET)
                   || (paddr == `PM_OFF_OVS_SET);

   // =======================================================================
   // Counting
   // =======================================================================
   logic [NM-1:0] hit;
   logic [NM-1:0] wrap;

   genvar g;
   generate
      for (g = 0; g < NM; g++) begin : g_mon
         logic          ev;
         logic [CW:0]   sum;
         // An event counts when selected and not masked off by the filter.
         assign ev   = event_in[g*NE + evsel_q[g]] && !filt_q[g][evsel_q[g]];
         assign hit[g] = run_q && cnten_q[g] && !count_prohibit && ev;
         assign sum  = {1'b0, value_q[g]} + {{CW{1'b0}}, 1'b1};
         assign wrap[g] = hit[g] && sum[CW];
      end
   endgenerate

   // =======================================================================
   // Write strobes per register group
   // =======================================================================
   logic wr_value;
   logic wr_evsel;
   logic wr_filt;
   logic wr_cnten;
   logic wr_inten;
   logic wr_ovs;
   logic wr_ctrl;

   assign wr_value = wr_en && (sel == SEL_VALUE);
   assign wr_evsel = wr_en && (sel == SEL_EVSEL);
   assign wr_filt  = wr_en && (sel == SEL_FILT);
   assign wr_cnten = wr_en && (sel == SEL_CNTEN);
   assign wr_inten = wr_en && (sel == SEL_INTEN);
   assign wr_ovs   = wr_en && (sel == SEL_OVS);
   assign wr_ctrl  = wr_en && (sel == SEL_CTRL) && pstrb[0];

   // =======================================================================
   // Monitor values
   // =======================================================================
   // A software write wins over an increment landing in the same cycle, so
   // software can preload a value without racing a busy event line.
   always_comb begin
      for (int i = 0; i < NM; i++) begin
         value_d[i] = hit[i] ? value_q[i] + CW'(1) : value_q[i];
      end
      if (wr_value) begin
         value_d[idx] = CW'(pwdata & wmask);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NM; i++) begin
            value_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NM; i++) begin
            value_q[i] <= value_d[i];
         end
      end
   end

   // =======================================================================
   // Event select and filter
   // =======================================================================
   always_comb begin
      for (int i = 0; i < NM; i++) begin
         evsel_d[i] = evsel_q[i];
         filt_d[i]  = filt_q[i];
      end
      if (wr_evsel) begin
         evsel_d[idx] = pwdata[EW-1:0];
      end
      if (wr_filt) begin
         filt_d[idx] = pwdata[NE-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NM; i++) begin
            evsel_q[i] <= '0;
            filt_q[i]  <= '0;
         end
      end else begin
         for (int i = 0; i < NM; i++) begin
            evsel_q[i] <= evsel_d[i];
            filt_q[i]  <= filt_d[i];
         end
      end
   end

   // =======================================================================
   // Monitor enable bits
   // =======================================================================
   always_comb begin
      cnten_d = cnten_q;
      if (wr_cnten) begin
         cnten_d = is_set ? (cnten_q | wbits) : (cnten_q & ~wbits);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnten_q <= '0;
      end else begin
         cnten_q <= cnten_d;
      end
   end

   // =======================================================================
   // Interrupt enable bits
   // =======================================================================
   always_comb begin
      inten_d = inten_q;
      if (wr_inten) begin
         inten_d = is_set ? (inten_q | wbits) : (inten_q & ~wbits);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         inten_q <= '0;
      end else begin
         inten_q <= inten_d;
      end
   end

   // =======================================================================
   // Overflow flag bits
   // =======================================================================
   always_comb begin
      ovs_d = ovs_q;
      if (wr_ovs) begin
         ovs_d = is_set ? (ovs_q | wbits) : (ovs_q & ~wbits);
      end
      // A hardware overflow wins over a clear written in the same cycle, so
      // an overflow is never lost while software services an earlier one.
      ovs_d = ovs_d | wrap;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovs_q <= '0;
      end else begin
         ovs_q <= ovs_d;
      end
   end

   // =======================================================================
   // Run control
   // =======================================================================
   always_comb begin
      run_d = run_q;
      if (wr_ctrl) begin
         run_d = pwdata[`PM_CTL_RUN_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_q <= 1'b0;
      end else begin
         run_q <= run_d;
      end
   end

   // =======================================================================
   // Bus answer
   // =======================================================================
   localparam logic [31:0] CFG_WORD = (32'(NM - 1) << `PM_CFG_COUNT_LSB)
                                      | (32'(CW - 1) << `PM_CFG_SIZE_LSB);

   logic rd_hit;
   logic wr_refused;

   // Unmapped reads return zero alongside the error.
   always_comb begin
      prdata_d = `PM_RST_WORD;
      rd_hit   = 1'b1;
      if (rd_en) begin
         unique case (sel)
            SEL_VALUE:  prdata_d = 32'(value_q[idx]);
            SEL_EVSEL:  prdata_d = 32'(evsel_q[idx]);
            SEL_FILT:   prdata_d = 32'(filt_q[idx]);
            SEL_CNTEN:  prdata_d = 32'(cnten_q);
            SEL_INTEN:  prdata_d = 32'(inten_q);
            SEL_OVS:    prdata_d = 32'(ovs_q);
            SEL_CTRL:   prdata_d = 32'(run_q);
            SEL_CONFIG: prdata_d = CFG_WORD;
            default:    rd_hit   = 1'b0;
         endcase
      end
   end

   // Unmapped addresses and the read-only config register refuse writes.
   assign wr_refused = wr_en && (sel == SEL_NONE || sel == SEL_CONFIG);

   always_comb begin
      pready_d  = psel && penable && !pready_q;
      pslverr_d = (rd_en && !rd_hit) || wr_refused;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata   <= `PM_RST_WORD;
         pready_q <= 1'b0;
         pslverr  <= 1'b0;
      end else begin
         prdata   <= prdata_d;
         pready_q <= pready_d;
         pslverr  <= pslverr_d;
      end
   end

   assign pready = pready_q;

   // =======================================================================
   // Overflow interrupt
   // =======================================================================
   // Registered so the output comes straight from a flop; it looks at the
   // next flag, enable and run values so that it changes in the same cycle as they do, without lag.
   always_comb begin
      irq_d = |(ovs_d & inten_d) && run_d;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_irq <= 1'b0;
      end else begin
         overflow_irq <= irq_d;
      end
   end

endmodule : perf_monitor_counter_bank

//--- pkg/perf_mon_defs.svh
/*
 * Offsets, field positions, reset values and sizes of the performance monitor bank.
 * Assumes inclusion by bare name from any file that needs the register map.
 */
`ifndef PERF_MON_DEFS_SVH
`define PERF_MON_DEFS_SVH

// ==========================================================================
// Bank shape
// ==========================================================================
`define PM_NUM_MON        8
`define PM_CNT_WIDTH      32
`define PM_MAX_WIDTH      64
`define PM_MAX_MON_NARROW 256
`define PM_MAX_MON_WIDE   128
`define PM_EVT_WIDTH      4

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define PM_OFF_VALUE_BASE 12'h000
`define PM_OFF_EVSEL_BASE 12'h400
`define PM_OFF_FILT_BASE  12'h600
`define PM_OFF_CNTEN_SET  12'hC00
`define PM_OFF_CNTEN_CLR  12'hC20
`define PM_OFF_INTEN_SET  12'hC40
`define PM_OFF_INTEN_CLR  12'hC60
`define PM_OFF_OVS_CLR    12'hC80
`define PM_OFF_OVS_SET    12'hCC0
`define PM_OFF_CONTROL    12'hE04
`define PM_OFF_CONFIG     12'hE00

// ==========================================================================
// Field positions and reset values
// ==========================================================================
`define PM_CFG_COUNT_LSB  0
`define PM_CFG_SIZE_LSB   8
`define PM_CTL_RUN_BIT    0
`define PM_RST_WORD       32'h0000_0000

`endif

//--- pkg/perf_mon_pkg.sv
/*
 * Types shared by the performance monitor bank.
 * Assumes the constants header sits alongside in pkg/.
 */
package perf_mon_pkg;

   // =======================================================================
   // Register selection
   // =======================================================================
   typedef enum logic [3:0] {
      SEL_NONE   = 4'b0000,
      SEL_VALUE  = 4'b0001,
      SEL_EVSEL  = 4'b0010,
      SEL_FILT   = 4'b0011,
      SEL_CNTEN  = 4'b0100,
      SEL_INTEN  = 4'b0101,
      SEL_OVS    = 4'b0110,
      SEL_CTRL   = 4'b0111,
      SEL_CONFIG = 4'b1000
   } reg_sel_e;

   typedef logic [31:0] word_t;

endpackage : perf_mon_pkg

//--- test/perf_bank_monitor.sv
/* Concurrent checks on the ports of the monitor bank.
   Assumes binding to the bank and the constants header on the include path. */
`timescale 1ns/1ps
`include "perf_mon_defs.svh"

module perf_bank_monitor (
   // Clock and reset
   input wire logic                                      pclk,
   input wire logic                                      presetn,
   // APB
   input wire logic                                      psel,
   input wire logic                                      penable,
   input wire logic                                      pwrite,
   input wire logic [11:0]                               paddr,
   input wire logic [31:0]                               prdata,
   input wire logic                                      pready,
   input wire logic                                      pslverr,
   // Events and interrupt
   input wire logic [`PM_NUM_MON*(1<<`PM_EVT_WIDTH)-1:0] event_in,
   input wire logic                                      count_prohibit,
   input wire logic                                      overflow_irq
);
   // The interrupt may only move one cycle after a write or a countable event.
   logic wr_q;
   logic ev_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_q <= 1'b0;
         ev_q <= 1'b0;
      end else begin
         wr_q <= psel && penable && pwrite && !pready;
         ev_q <= (|event_in) && !count_prohibit;
      end
   end
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready stood longer than one cycle");
   a_ready_latency: assert property (psel && penable && !pready |=> pready)
      else $error("ready late");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_err_data_zero: assert property (pslverr |-> prdata == 32'h0000_0000)
      else $error("error with data");
   a_config_read_only: assert property (pready && pwrite && paddr == `PM_OFF_CONFIG |-> pslverr)
      else $error("config write accepted");
   a_config_read_value: assert property (pready && !pwrite && paddr == `PM_OFF_CONFIG
      |-> prdata == 32'h0000_1F07)
      else $error("config value wrong");
   a_irq_rise_cause: assert property ($rose(overflow_irq) |-> wr_q || ev_q)
      else $error("interrupt rose without cause");
   a_irq_fall_cause: assert property ($fell(overflow_irq) |-> wr_q)
      else $error("interrupt fell without write");
endmodule : perf_bank_monitor

bind perf_monitor_counter_bank perf_bank_monitor mon_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .event_in(event_in), .count_prohibit(count_prohibit),
   .overflow_irq(overflow_irq));

//--- test/perf_monitor_counter_bank_bench.sv
/* Self-checking bench: set and clear rows, refusals, counting, overflow, reset.
   Assumes the package and constants header are compiled first. */
`timescale 1ns/1ps
`include "perf_mon_defs.svh"

module perf_monitor_counter_bank_bench
   import perf_mon_pkg::*;
();
   // ==========================================================================
   // Signals
   // ==========================================================================
   logic         pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic         count_prohibit = 1'b0, pready, pslverr, overflow_irq, er;
   logic [11:0]  paddr = 12'h000;
   logic [3:0]   pstrb = 4'hF;
   word_t        pwdata = 32'h0000_0000, prdata, rd;
   logic [`PM_NUM_MON*(1<<`PM_EVT_WIDTH)-1:0] event_in = '0;
   int           err_total = 0, tests_run = 0;
   typedef struct { logic [11:0] wa; word_t wd; logic [11:0] ra; word_t ex; } row_s;
   row_s         rows [8];

   perf_monitor_counter_bank dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_in(event_in),
      .count_prohibit(count_prohibit), .overflow_irq(overflow_irq));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // ==========================================================================
   // Tasks
   // ==========================================================================
   task automatic chk(input word_t seen, input word_t exp);
      tests_run++;
      if (seen !== exp) begin
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         err_total++;
      end
   endtask : chk

   // The trailing idle edge keeps two transfers from driving psel twice in one step.
   task automatic apb(input logic w, input logic [11:0] a, input word_t d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) err_total++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic pulse(input int bit_no);
      event_in[bit_no] <= 1'b1;
      repeat (3) @(posedge pclk);
      event_in[bit_no] <= 1'b0;
      @(posedge pclk);
   endtask : pulse

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict

   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      give_verdict();
   end

   // ==========================================================================
   // Tests
   // ==========================================================================
   initial begin
      rows = '{'{`PM_OFF_CNTEN_SET, 32'h0000_00A5, `PM_OFF_CNTEN_CLR, 32'h0000_00A5},
               '{`PM_OFF_CNTEN_CLR, 32'h0000_0021, `PM_OFF_CNTEN_SET, 32'h0000_0084},
               '{`PM_OFF_INTEN_SET, 32'hFFFF_FF0F, `PM_OFF_INTEN_CLR, 32'h0000_000F},
               '{`PM_OFF_INTEN_CLR, 32'h0000_0000, `PM_OFF_INTEN_SET, 32'h0000_000F},
               '{`PM_OFF_OVS_SET, 32'h0000_0003, `PM_OFF_OVS_CLR, 32'h0000_0003},
               '{`PM_OFF_OVS_CLR, 32'h0000_0001, `PM_OFF_OVS_SET, 32'h0000_0002},
               '{12'h010, 32'h1234_5678, 12'h010, 32'h1234_5678},
               '{12'h408, 32'h0000_0005, 12'h408, 32'h0000_0005}};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) begin
         apb(1'b1, rows[i].wa, rows[i].wd);
         apb(1'b0, rows[i].ra, 32'h0000_0000);
         chk(rd, rows[i].ex);
      end
      $display("test set and clear rows done");
      apb(1'b0, `PM_OFF_CONFIG, 32'h0000_0000);
      chk(rd, 32'h0000_1F07);
      apb(1'b1, `PM_OFF_CONFIG, 32'hFFFF_FFFF);
      chk({31'h0000_0000, er}, 32'h0000_0001);
      apb(1'b0, 12'hF00, 32'h0000_0000);
      chk({rd[30:0], er}, 32'h0000_0001);
      apb(1'b1, 12'hD00, 32'h0000_0001);
      chk({31'h0000_0000, er}, 32'h0000_0001);
      $display("test refusals done");
      chk({31'h0000_0000, overflow_irq}, 32'h0000_0000);
      apb(1'b1, 12'h008, 32'hFFFF_FFFE);
      apb(1'b1, `PM_OFF_CONTROL, 32'h0000_0001);
      pulse(37);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      apb(1'b0, `PM_OFF_OVS_SET, 32'h0000_0000);
      chk(rd, 32'h0000_0006);
      chk({31'h0000_0000, overflow_irq}, 32'h0000_0001);
      count_prohibit <= 1'b1;
      pulse(37);
      count_prohibit <= 1'b0;
      pulse(36);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      apb(1'b1, 12'h608, 32'h0000_0020);
      pulse(37);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      apb(1'b0, 12'h608, 32'h0000_0000);
      chk(rd, 32'h0000_0020);
      apb(1'b1, `PM_OFF_CONTROL, 32'h0000_0000);
      pulse(37);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      chk({31'h0000_0000, overflow_irq}, 32'h0000_0000);
      $display("test counting done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `PM_OFF_CNTEN_SET, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      $display("test reset done");
      give_verdict();
   end
endmodule : perf_monitor_counter_bank_bench
